//--- design/xpc_pkg.sv
package xpc_pkg;

   // Switch geometry and serial frame layout
   localparam int NUM_OUT       = 16;
   localparam int SEL_W         = 5;
   localparam int FIELD_W       = SEL_W + 1;
   localparam int FRAME_BITS    = NUM_OUT * FIELD_W;
   localparam int FIELD_OFF_POS = SEL_W;

   // Reset and broadcast values of one output entry
   localparam logic [SEL_W-1:0] SEL_RST    = 5'h00;
   localparam logic             OFF_RST    = 1'h1;
   localparam logic [SEL_W-1:0] SEL_BCAST  = 5'h00;
   localparam logic             OFF_BCAST  = 1'h0;

   // Mode pin encoding
   localparam logic MODE_SERIAL = 1'h0;

   // Pin vector positions through the synchroniser
   localparam int PIN_SCLK  = 0;
   localparam int PIN_SELN  = 1;
   localparam int PIN_SDI   = 2;
   localparam int PIN_MODE  = 3;
   localparam int PIN_CFG   = 4;
   localparam int PIN_RSTO  = 5;
   localparam int PIN_BCAST = 6;
   localparam int NUM_PINS  = 7;

   // Idle pin levels: select high, everything else low
   localparam logic [NUM_PINS-1:0] PIN_IDLE = 7'h02;

   // Synchroniser depth
   localparam int SYNC_STAGES = 3;

endpackage

//--- design/xpc_pin_if.sv
`timescale 1ns/1ps
interface xpc_pin_if #(
   parameter int N = 1
);
   logic [N-1:0] lvl;
   logic [N-1:0] rise;
   logic [N-1:0] fall;

   modport src (output lvl, output rise, output fall);
   modport dst (input  lvl, input  rise, input  fall);
endinterface

//--- design/xpc_pin_sync.sv
`timescale 1ns/1ps
module xpc_pin_sync
   import xpc_pkg::*;
#(
   parameter int          N       = NUM_PINS,
   parameter logic [N-1:0] RST_VAL = PIN_IDLE
) (
   input  wire logic         mclk_i,  // System clock
   input  wire logic         rst_i,   // Synchronous reset, active high
   input  wire logic [N-1:0] raw_i,   // Asynchronous pin levels
   xpc_pin_if.src            pins     // Filtered levels and edge pulses
);

   ////////////////////////////////////////////////////////////////////////////
   // One three-stage chain per pin; a level is accepted once stages two and
   // three agree, which filters a single-cycle glitch on a slow host pin.
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_pin
         logic s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
         logic lvl_nxt, rise_nxt, fall_nxt;

         // Next filtered level and its edges
         always_comb begin
            lvl_nxt  = (s2_r == s3_r) ? s3_r : lvl_r;
            rise_nxt = lvl_nxt & ~lvl_r;
            fall_nxt = ~lvl_nxt & lvl_r;
         end

         // First stage feeds only the second
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               s1_r   <= RST_VAL[g];
               s2_r   <= RST_VAL[g];
               s3_r   <= RST_VAL[g];
               lvl_r  <= RST_VAL[g];
               rise_r <= 1'h0;
               fall_r <= 1'h0;
            end else begin
               s1_r   <= raw_i[g];
               s2_r   <= s1_r;
               s3_r   <= s2_r;
               lvl_r  <= lvl_nxt;
               rise_r <= rise_nxt;
               fall_r <= fall_nxt;
            end
         end

         assign pins.lvl[g]  = lvl_r;
         assign pins.rise[g] = rise_r;
         assign pins.fall[g] = fall_r;
      end
   endgenerate

endmodule

//--- design/xpc_config.sv
`timescale 1ns/1ps
// Summary of operation
// - Serial output carries the chain stream only in serial mode.
// - While shifting, serial output presents the bits already held in the register.
// - After a full 96-bit frame, each further shift sends its first bit onward.
// - One configure strobe updates all chained devices together, or each separately.
// - Reset override high holds every output disabled.
// - Reset override writes input 0 and off into every output entry.
// - Broadcast override high, with reset override low, enables every output on input 0.
// - Overrides act on level, without any shift clock edge.
// - Overrides ignore the serial bus and overwrite the active configuration.
// - Mode low selects serial programming; mode high stops shifting, as addressed programming is not built.
// - Frame is 16 six-bit fields, select LSB first then off bit, output 0 first.
// - Shifted data changes routing only on a configure pulse.
module xpc_config
   import xpc_pkg::*;
#(
   parameter int N_OUT = NUM_OUT,
   parameter int SW    = SEL_W
) (
   input  wire logic                  mclk_i,                     // System clock, 125 MHz
   input  wire logic                  rst_i,                      // Synchronous reset, active high
   input  wire logic                  sclk_i,                     // Host shift clock pin
   input  wire logic                  sel_n_i,                    // Host select pin, active low
   input  wire logic                  sdi_i,                      // Serial data in pin
   input  wire logic                  mode_i,                     // Mode pin, low is serial
   input  wire logic                  cfg_i,                      // Configure strobe pin
   input  wire logic                  ovr_reset_i,                // Reset override pin, active high
   input  wire logic                  force_all_on_input_zero_i,  // Broadcast override pin
   output logic                       sdo_o,                      // Serial data out to next device
   output logic [N_OUT*SW-1:0]        route_sel_o,                // Input selection per output
   output logic [N_OUT-1:0]           out_off_o                   // 1 = output high impedance
);

   localparam int FW    = SW + 1;
   localparam int FBITS = N_OUT * FW;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks: forced entries are built from the package select
   // width, so any other SW would misalign every field of the frame.

   generate
      if (N_OUT < 1) begin : g_bad_nout
         $error("xpc_config: N_OUT must be positive");
      end
      if (SW != SEL_W) begin : g_bad_sw
         $error("xpc_config: SW must equal the package select width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Timing limits
   // Every pin crosses three flops and a level counts once stages two and
   // three agree, so a pin change is seen about four clocks later.
   // The host must hold each shift clock level, data bit and select level
   // for at least two clocks; a faster host loses bits.
   // Data and shift clock share the same path and delay, so their relation
   // at the pins carries over to the sampling edge.
   // Overrides use this path too: they act about five clocks after the pin
   // moves, with no shift clock, and the outputs stay glitch-free flops.

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [NUM_PINS-1:0] raw_pins;

   assign raw_pins[PIN_SCLK]  = sclk_i;
   assign raw_pins[PIN_SELN]  = sel_n_i;
   assign raw_pins[PIN_SDI]   = sdi_i;
   assign raw_pins[PIN_MODE]  = mode_i;
   assign raw_pins[PIN_CFG]   = cfg_i;
   assign raw_pins[PIN_RSTO]  = ovr_reset_i;
   assign raw_pins[PIN_BCAST] = force_all_on_input_zero_i;

   xpc_pin_if #(.N(NUM_PINS)) pins ();

   xpc_pin_sync #(
      .N       (NUM_PINS),
      .RST_VAL (PIN_IDLE)
   ) u_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .raw_i  (raw_pins),
      .pins   (pins)
   );

   logic sclk_rise, sclk_fall, sel_low, sdi_lvl, serial_mode, cfg_rise, rst_ovr, bcast_ovr;

   // Decoded pin views
   always_comb begin
      sclk_rise   = pins.rise[PIN_SCLK];
      sclk_fall   = pins.fall[PIN_SCLK];
      sel_low     = ~pins.lvl[PIN_SELN];
      sdi_lvl     = pins.lvl[PIN_SDI];
      serial_mode = (pins.lvl[PIN_MODE] == MODE_SERIAL);
      cfg_rise    = pins.rise[PIN_CFG];
      rst_ovr     = pins.lvl[PIN_RSTO];
      bcast_ovr   = pins.lvl[PIN_BCAST];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial front end: arming and shift register

   typedef enum logic {
      PORT_IDLE,
      PORT_ARMED
   } xpc_port_state_t;

   xpc_port_state_t  port_r,   port_nxt;
   logic [FBITS-1:0] shift_r,  shift_nxt;
   logic             sdo_r,    sdo_nxt;
   logic             do_shift;

   // A rising clock seen with select low arms the port; bits are then taken on
   // falling edges. Raising select disarms, so a free-running clock after the
   // frame cannot push valid data past its place.
   always_comb begin
      port_nxt = port_r;
      case (port_r)
         PORT_IDLE: begin
            if (sel_low && sclk_rise) begin
               port_nxt = PORT_ARMED;
            end
         end
         PORT_ARMED: begin
            if (!sel_low) begin
               port_nxt = PORT_IDLE;
            end
         end
         default: begin
            port_nxt = PORT_IDLE;
         end
      endcase
   end

   // Port state register
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         port_r <= PORT_IDLE;
      end else begin
         port_r <= port_nxt;
      end
   end

   // Addressed mode is not built: in that mode nothing shifts and the chain
   // output rests low, since chaining exists only in serial mode.
   always_comb begin
      do_shift  = (port_r == PORT_ARMED) && sel_low && sclk_fall && serial_mode;
      shift_nxt = shift_r;
      if (do_shift) begin
         shift_nxt = {shift_r[FBITS-2:0], sdi_lvl};
      end
      // The oldest held bit leads onward: stale bits first, then the new frame
      sdo_nxt = serial_mode ? shift_nxt[FBITS-1] : 1'h0;
   end

   // Shift state registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         shift_r <= '0;
         sdo_r   <= 1'h0;
      end else begin
         shift_r <= shift_nxt;
         sdo_r   <= sdo_nxt;
      end
   end

   assign sdo_o = sdo_r;

   ////////////////////////////////////////////////////////////////////////////
   // Active configuration register

   logic [N_OUT*SW-1:0] sel_r, sel_nxt;
   logic [N_OUT-1:0]    off_r, off_nxt;
   logic [N_OUT*SW-1:0] frame_sel;
   logic [N_OUT-1:0]    frame_off;

   // Unpack the frame: first bit in sits at the top, so output 0 is the top
   // field and each select arrives LSB first.
   genvar k, b;
   generate
      for (k = 0; k < N_OUT; k = k + 1) begin : g_field
         for (b = 0; b < SW; b = b + 1) begin : g_bit
            assign frame_sel[k*SW+b] = shift_r[FBITS-1-k*FW-b];
         end
         assign frame_off[k] = shift_r[FBITS-1-k*FW-SW];
      end
   endgenerate

   // Overrides need no shift clock and win over any configure strobe; reset
   // override outranks broadcast. Level-held overrides keep rewriting the
   // entries, so the forced values stay after the pin drops.
   always_comb begin
      sel_nxt = sel_r;
      off_nxt = off_r;
      if (rst_ovr) begin
         sel_nxt = {N_OUT{SEL_RST}};
         off_nxt = {N_OUT{OFF_RST}};
      end else if (bcast_ovr) begin
         sel_nxt = {N_OUT{SEL_BCAST}};
         off_nxt = {N_OUT{OFF_BCAST}};
      end else if (cfg_rise) begin
         sel_nxt = frame_sel;
         off_nxt = frame_off;
      end
   end

   // Whole-register update in one edge, so no partial routing is ever seen
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sel_r <= {N_OUT{SEL_RST}};
         off_r <= {N_OUT{OFF_RST}};
      end else begin
         sel_r <= sel_nxt;
         off_r <= off_nxt;
      end
   end

   assign route_sel_o = sel_r;
   assign out_off_o   = off_r;

endmodule

//--- test/xpc_config_asserts.sv
`timescale 1ns/1ps
module xpc_config_asserts
   import xpc_pkg::*;
#(
   parameter int N_OUT = NUM_OUT,
   parameter int SW    = SEL_W
) (
   input wire logic                mclk_i,                     // Clock
   input wire logic                rst_i,                      // Reset
   input wire logic                sclk_i,                     // Shift clock
   input wire logic                sel_n_i,                    // Select
   input wire logic                sdi_i,                      // Data in
   input wire logic                mode_i,                     // Mode
   input wire logic                cfg_i,                      // Strobe
   input wire logic                ovr_reset_i,                // Reset pin
   input wire logic                force_all_on_input_zero_i,  // Broadcast
   input wire logic                sdo_o,                      // Data out
   input wire logic [N_OUT*SW-1:0] route_sel_o,                // Routing
   input wire logic [N_OUT-1:0]    out_off_o                   // Off flags
);
   logic quiet;
   // Windows allow for the pin synchroniser delay
   assign quiet = !cfg_i && !ovr_reset_i && !force_all_on_input_zero_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   chk_mode_sdo_low: assert property (mode_i [*6] |-> !sdo_o)
      else $error("serial out active in addressed mode");
   chk_rst_all_off: assert property (ovr_reset_i [*6] |-> &out_off_o)
      else $error("output on under reset override");
   chk_rst_sel_zero: assert property (ovr_reset_i [*6] |-> route_sel_o == '0)
      else $error("selection not zero under reset override");
   chk_bcast_all_on: assert property ((force_all_on_input_zero_i && !ovr_reset_i) [*6]
      |-> out_off_o == '0 && route_sel_o == '0) else $error("broadcast not applied");
   chk_rst_no_sclk: assert property ($rose(ovr_reset_i) |-> ##[1:6] &out_off_o)
      else $error("reset override too slow");
   chk_bcast_no_bus: assert property ($rose(force_all_on_input_zero_i) && !ovr_reset_i
      |-> ##[1:6] out_off_o == '0) else $error("broadcast too slow");
   chk_route_hold: assert property (quiet [*8] |-> $stable(route_sel_o) && $stable(out_off_o))
      else $error("routing changed without strobe");
   chk_sdo_on_shift: assert property ((!mode_i && $stable(sclk_i)) [*8] |-> $stable(sdo_o))
      else $error("serial out moved without shift");
endmodule
////////////////////////////////////////////////////////////////////////
bind xpc_config xpc_config_asserts #(.N_OUT(N_OUT), .SW(SW)) u_xpc_config_asserts (
   .mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sel_n_i(sel_n_i), .sdi_i(sdi_i), .mode_i(mode_i),
   .cfg_i(cfg_i), .ovr_reset_i(ovr_reset_i), .force_all_on_input_zero_i(force_all_on_input_zero_i),
   .sdo_o(sdo_o), .route_sel_o(route_sel_o), .out_off_o(out_off_o));

//--- test/xpc_host_model.sv
`timescale 1ns/1ps
module xpc_host_model (
   input  wire logic mclk_i,   // System clock
   output logic      sclk_o,   // Shift clock, low when idle; pulsed once more after select rises
   output logic      sel_n_o,  // Select shared by both devices
   output logic      sd_o,     // Serial data
   output logic      cfg_o,                     // Strobe shared by both devices
   output logic      mode_o,                    // Mode shared by both devices
   output logic      ovr_reset_o,               // Reset override to both devices
   output logic      force_all_on_input_zero_o  // Broadcast override to both devices
);
   // Idle levels at time zero
   initial begin
      sclk_o = 1'h0;
      sel_n_o = 1'h1;
      sd_o = 1'h0;
      cfg_o = 1'h0;
      mode_o = 1'h0;
      ovr_reset_o = 1'h0;
      force_all_on_input_zero_o = 1'h0;
   end
   // Level pins, moved just after a clock edge like every other host line
   task automatic levels(input logic m, input logic r, input logic b);
      mode_o = m;
      ovr_reset_o = r;
      force_all_on_input_zero_o = b;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // Slow clock keeps every level well past the pin synchroniser
   task automatic load(input logic [191:0] b);
      sel_n_o = 1'h0;
      tick(6);
      for (int i = 0; i < 192; i++) begin
         sclk_o = 1'h1;
         sd_o = b[i];
         tick(6);
         sclk_o = 1'h0;
         tick(6);
      end
      sel_n_o = 1'h1;
      sd_o = ~sd_o; // Released line must not keep its last bit
      tick(6);
      sclk_o = 1'h1;
      tick(6);
      sclk_o = 1'h0;
      tick(6);
   endtask
   // Strobe only after shifting is over
   task automatic strobe();
      cfg_o = 1'h1;
      tick(6);
      cfg_o = 1'h0;
      tick(10);
   endtask
endmodule

//--- test/xpc_config_tb.sv
`timescale 1ns/1ps
module xpc_config_tb
   import xpc_pkg::*;
;
   logic                      clk, rst;
   wire logic                 sclk, seln, sd, cfg, link, mode, ovr, bc;
   logic [NUM_OUT*SEL_W-1:0]  route_a, route_b;
   logic [NUM_OUT-1:0]        off_a, off_b;
   int                        fail_count, n_tests, cyc;
   localparam logic [95:0]    RST_EXP = {80'h0, 16'hFFFF};
   // Two devices chained, all host lines but serial data in common
   xpc_host_model u_xpc_host_model (.mclk_i(clk), .sclk_o(sclk), .sel_n_o(seln), .sd_o(sd), .cfg_o(cfg),
      .mode_o(mode), .ovr_reset_o(ovr), .force_all_on_input_zero_o(bc));
   xpc_config u_xpc_config (.mclk_i(clk), .rst_i(rst), .sclk_i(sclk), .sel_n_i(seln), .sdi_i(sd),
      .mode_i(mode), .cfg_i(cfg), .ovr_reset_i(ovr), .force_all_on_input_zero_i(bc), .sdo_o(link),
      .route_sel_o(route_a), .out_off_o(off_a));
   xpc_config u_xpc_config_nx (.mclk_i(clk), .rst_i(rst), .sclk_i(sclk), .sel_n_i(seln), .sdi_i(link),
      .mode_i(mode), .cfg_i(cfg), .ovr_reset_i(ovr), .force_all_on_input_zero_i(bc), .sdo_o(),
      .route_sel_o(route_b), .out_off_o(off_b));
   always #4 clk = ~clk;
   task automatic report_and_stop();
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well above the three frame loads
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Frame bits in send order: per output five select bits, then off
   function automatic logic [95:0] fr(input int d);
      for (int k = 0; k < NUM_OUT; k++) fr[6*k +: 6] = 6'((((k + d) & 1) << 5) | ((k * 3 + d) & 31));
   endfunction
   function automatic logic [95:0] ex(input logic [95:0] f);
      for (int k = 0; k < NUM_OUT; k++) ex[16+5*k +: 5] = f[6*k +: 5];
      for (int k = 0; k < NUM_OUT; k++) ex[k] = f[6*k+5];
   endfunction
   task automatic t_chain(input int d1, input int d2, input logic [95:0] pa, input logic [95:0] pb);
      u_xpc_host_model.load({fr(d1), fr(d2)});
      cmp({route_a, off_a}, pa);
      cmp({route_b, off_b}, pb);
      u_xpc_host_model.strobe();
      cmp({route_a, off_a}, ex(fr(d1)));
      cmp({route_b, off_b}, ex(fr(d2)));
   endtask
   task automatic t_mode();
      u_xpc_host_model.levels(1'h1, 1'h0, 1'h0);
      u_xpc_host_model.tick(8);
      u_xpc_host_model.load({fr(9), fr(11)});
      cmp({95'h0, link}, 96'h0);
      u_xpc_host_model.levels(1'h0, 1'h0, 1'h0);
      u_xpc_host_model.tick(8);
      u_xpc_host_model.strobe();
      cmp({route_a, off_a}, ex(fr(5)));
      cmp({route_b, off_b}, ex(fr(6)));
   endtask
   task automatic t_ovr();
      u_xpc_host_model.levels(1'h0, 1'h0, 1'h1);
      u_xpc_host_model.tick(8);
      cmp({route_b, off_b}, 96'h0);
      u_xpc_host_model.levels(1'h0, 1'h1, 1'h1);
      u_xpc_host_model.tick(8);
      cmp({route_a, off_a}, RST_EXP);
      u_xpc_host_model.levels(1'h0, 1'h1, 1'h0);
      u_xpc_host_model.tick(8);
      cmp({route_b, off_b}, RST_EXP);
      u_xpc_host_model.levels(1'h0, 1'h0, 1'h0);
      u_xpc_host_model.tick(8);
      cmp({route_a, off_a}, RST_EXP);
   endtask
   // Main sequence
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      u_xpc_host_model.tick(20);
      rst = 1'h0;
      u_xpc_host_model.tick(2);
      t_chain(1, 2, RST_EXP, RST_EXP);
      t_chain(5, 6, ex(fr(1)), ex(fr(2)));
      t_mode();
      t_ovr();
      report_and_stop();
   end
endmodule
